// >>> hdl/spdm_defines.svh
// Purpose: constants for the stereo pulse-density front end
// Assumes: 20 MHz processing clock, one clock domain
// Notes: offsets none; all control is plain ports
`ifndef SPDM_DEFINES_SVH
`define SPDM_DEFINES_SVH
`define SPDM_CLK_HZ 20000000
`define SPDM_MIC_MIN_HZ 1000000
`define SPDM_MIC_MAX_HZ 3200000
`define SPDM_DIV_MIN 9'h002
`define SPDM_DIV_MAX 9'h100
`define SPDM_DIV_MIN_PROC 4
`define SPDM_DIV_FAST (`SPDM_CLK_HZ / `SPDM_MIC_MAX_HZ)
`define SPDM_DIV_SLOW (`SPDM_CLK_HZ / `SPDM_MIC_MIN_HZ)
`define SPDM_DIV_RST 9'h010
`define SPDM_OSR_RST 8'h40
`define SPDM_ACC_W 9
`define SPDM_FIFO_W 10
`define SPDM_FIFO_D 16
`endif

// >>> hdl/spdm_pkg.sv
// Purpose: types shared by the front end
// Assumes: nothing beyond the defines header
// Notes: states of the per-channel skip control
package spdm_pkg;
	typedef enum logic [1:0] {
		SPDM_IDLE = 2'b00,
		SPDM_RUN = 2'b01,
		SPDM_SKIP = 2'b10
	} spdm_state_t;
endpackage

// >>> hdl/spdm_front.sv
// Purpose: stereo pulse-density split, clock divider, bit skip and decimation counters
// Assumes: data pins synchronous to clock_i; divider keeps processing >= 4x bit rate
// Notes: filter is a plain bit accumulator per output; each channel has a 16 word fifo
`timescale 1ns/1ps
`include "spdm_defines.svh"

// ****************************************
// fifo
// ****************************************
module spdm_fifo #(
	parameter int WIDTH = `SPDM_FIFO_W,
	parameter int DEPTH = `SPDM_FIFO_D
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	// handshakes come straight from the fill count
	assign in_ready_o = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem[rd_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// pointer and count update
	always_comb begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage has no reset; only read behind a valid count
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end
endmodule

// ****************************************
// one channel: skip control and decimation
// ****************************************
module spdm_chan (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic bit_en_i,
	input wire logic bit_i,
	input wire logic start_i,
	input wire logic enable_i,
	input wire logic [7:0] oversampling_ratio_i,
	input wire logic skip_load_i,
	input wire logic [7:0] skip_count_i,
	output logic skip_busy_o,
	output logic [`SPDM_ACC_W-1:0] sample_o,
	output logic sample_valid_o,
	input wire logic sample_ready_i,
	output logic overrun_o
);
	spdm_pkg::spdm_state_t st_q, st_d;
	logic [7:0] skip_q, skip_d;
	logic [7:0] bits_q, bits_d;
	logic [`SPDM_ACC_W-1:0] acc_q, acc_d;
	logic accept, done, f_ready, ovr_q, ovr_d;
	logic [`SPDM_FIFO_W-1:0] f_out;

	// gated clock enable: a skipped bit never produces an accept strobe
	assign accept = bit_en_i & (st_q == spdm_pkg::SPDM_RUN);
	assign done = accept & (bits_q == oversampling_ratio_i - 8'h01);
	assign skip_busy_o = (st_q == spdm_pkg::SPDM_SKIP);

	always_comb begin
		st_d = st_q;
		skip_d = skip_q;
		bits_d = bits_q;
		acc_d = acc_q;
		ovr_d = ovr_q & enable_i;
		case (st_q)
			spdm_pkg::SPDM_IDLE: begin
				if (enable_i & start_i) begin
					st_d = spdm_pkg::SPDM_RUN;
					bits_d = 8'h00;
					acc_d = '0;
				end
			end
			spdm_pkg::SPDM_RUN: begin
				if (skip_load_i && skip_count_i != 8'h00) begin
					st_d = spdm_pkg::SPDM_SKIP;
					skip_d = skip_count_i;
				end
				if (accept) begin
					// raw bit summed as a one-bit modulator stream
					acc_d = done ? '0 : acc_q + {{(`SPDM_ACC_W-1){1'b0}}, bit_i};
					bits_d = done ? 8'h00 : bits_q + 8'h01;
					if (done & ~f_ready) begin
						ovr_d = 1'b1;
					end
				end
			end
			spdm_pkg::SPDM_SKIP: begin
				// masked bits leave the bit count untouched, so the output waits
				if (bit_en_i) begin
					skip_d = skip_q - 8'h01;
					if (skip_q == 8'h01) begin
						st_d = spdm_pkg::SPDM_RUN;
					end
				end
			end
			default: st_d = spdm_pkg::SPDM_IDLE;
		endcase
		if (start_i & enable_i) begin
			st_d = spdm_pkg::SPDM_RUN;
			bits_d = 8'h00;
			acc_d = '0;
		end
		if (!enable_i) begin
			st_d = spdm_pkg::SPDM_IDLE;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= spdm_pkg::SPDM_IDLE;
			skip_q <= 8'h00;
			bits_q <= 8'h00;
			acc_q <= '0;
			ovr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			skip_q <= skip_d;
			bits_q <= bits_d;
			acc_q <= acc_d;
			ovr_q <= ovr_d;
		end
	end
	assign overrun_o = ovr_q;

	// own output flow per channel; a full fifo drops the sample and flags overrun
	spdm_fifo #(.WIDTH(`SPDM_FIFO_W), .DEPTH(`SPDM_FIFO_D)) u_fifo (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.in_valid_i(done),
		.in_ready_o(f_ready),
		.in_data_i({1'b0, acc_q + {{(`SPDM_ACC_W-1){1'b0}}, bit_i}}),
		.out_valid_o(sample_valid_o),
		.out_ready_i(sample_ready_i),
		.out_data_o(f_out)
	);
	assign sample_o = f_out[`SPDM_ACC_W-1:0];
endmodule

// ****************************************
// top: clock out, edge split, two channels
// ****************************************
module spdm_front (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic [8:0] mic_clock_divider_i,
	input wire logic clock_enable_i,
	output logic mic_clock_out_o,
	input wire logic serial_data_in_pin_x_i,
	input wire logic serial_data_in_pin_x1_i,
	input wire logic redirect_x_i,
	input wire logic [1:0] chan_enable_i,
	input wire logic start_i,
	input wire logic [7:0] oversampling_ratio_i,
	input wire logic [1:0] skip_load_i,
	input wire logic [7:0] skip_count_x_i,
	input wire logic [7:0] skip_count_x1_i,
	output logic [1:0] skip_busy_o,
	output logic [`SPDM_ACC_W-1:0] sample_x_o,
	output logic sample_x_valid_o,
	input wire logic sample_x_ready_i,
	output logic [`SPDM_ACC_W-1:0] sample_x1_o,
	output logic sample_x1_valid_o,
	input wire logic sample_x1_ready_i,
	output logic [1:0] overrun_o
);
	logic [8:0] div_q, div_d, cnt_q, cnt_d;
	logic ck_q, ck_d, rise, fall, data_x;
	logic [1:0] en_q;

	// divider value clamped to the legal range; below 4 the processing margin is lost
	always_comb begin
		div_d = mic_clock_divider_i;
		if (mic_clock_divider_i < 9'(`SPDM_DIV_MIN_PROC)) begin
			div_d = 9'(`SPDM_DIV_MIN_PROC);
		end else if (mic_clock_divider_i > `SPDM_DIV_MAX) begin
			div_d = `SPDM_DIV_MAX;
		end
	end

	// period of div clocks, high for the first half
	always_comb begin
		cnt_d = cnt_q;
		ck_d = ck_q;
		if (!clock_enable_i) begin
			cnt_d = 9'h000;
			ck_d = 1'b0;
		end else if (cnt_q >= div_q - 9'h001) begin
			cnt_d = 9'h000;
			ck_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 9'h001;
			if (cnt_q + 9'h001 == {1'b0, div_q[8:1]}) begin
				ck_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_q <= `SPDM_DIV_RST;
			cnt_q <= 9'h000;
			ck_q <= 1'b0;
		end else begin
			div_q <= div_d;
			cnt_q <= cnt_d;
			ck_q <= ck_d;
		end
	end
	assign mic_clock_out_o = ck_q;

	// edges of our own clock output, one strobe each per period
	assign rise = ck_d & ~ck_q;
	assign fall = ~ck_d & ck_q;
	assign data_x = redirect_x_i ? serial_data_in_pin_x1_i : serial_data_in_pin_x_i;
	assign en_q = chan_enable_i;

	spdm_chan u_ch_x (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.bit_en_i(rise),
		.bit_i(data_x),
		.start_i(start_i),
		.enable_i(en_q[0]),
		.oversampling_ratio_i(oversampling_ratio_i),
		.skip_load_i(skip_load_i[0]),
		.skip_count_i(skip_count_x_i),
		.skip_busy_o(skip_busy_o[0]),
		.sample_o(sample_x_o),
		.sample_valid_o(sample_x_valid_o),
		.sample_ready_i(sample_x_ready_i),
		.overrun_o(overrun_o[0])
	);

	spdm_chan u_ch_x1 (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.bit_en_i(fall),
		.bit_i(serial_data_in_pin_x1_i),
		.start_i(start_i),
		.enable_i(en_q[1]),
		.oversampling_ratio_i(oversampling_ratio_i),
		.skip_load_i(skip_load_i[1]),
		.skip_count_i(skip_count_x1_i),
		.skip_busy_o(skip_busy_o[1]),
		.sample_o(sample_x1_o),
		.sample_valid_o(sample_x1_valid_o),
		.sample_ready_i(sample_x1_ready_i),
		.overrun_o(overrun_o[1])
	);
endmodule

// >>> verification/spdm_front_assertions.sv
// Purpose: port checks on spdm_front
// Assumes: one clock domain
// Notes: bound from tb
`timescale 1ns/1ps
`include "spdm_defines.svh"
module spdm_front_assertions (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic clock_enable_i,
	input wire logic mic_clock_out_o,
	input wire logic [1:0] chan_enable_i,
	input wire logic [1:0] skip_load_i,
	input wire logic [7:0] skip_count_x1_i,
	input wire logic [1:0] skip_busy_o,
	input wire logic [7:0] oversampling_ratio_i,
	input wire logic [`SPDM_ACC_W-1:0] sample_x_o,
	input wire logic sample_x_valid_o,
	input wire logic sample_x_ready_i,
	input wire logic [1:0] overrun_o
);
// ********
// checks
// ********
	// divider floor of 4 gives each clock phase two cycles at least
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	clk_high_a: assert property ($rose(mic_clock_out_o) && clock_enable_i |=> mic_clock_out_o)
		else $error("short high");
	clk_low_a: assert property ($fell(mic_clock_out_o) |=> !mic_clock_out_o)
		else $error("short low");
	clk_max_a: assert property (mic_clock_out_o |-> ##[1:128] !mic_clock_out_o)
		else $error("long high");
	clk_off_a: assert property (!clock_enable_i |=> !mic_clock_out_o)
		else $error("clock not held");
	idle_x_a: assert property (!chan_enable_i[0] |=> !skip_busy_o[0] && !overrun_o[0])
		else $error("x not idle");
	zero_skip_a: assert property (skip_load_i[1] && skip_count_x1_i == 8'h00 && !skip_busy_o[1] |=> !skip_busy_o[1])
		else $error("zero skip taken");
	hold_x_a: assert property (sample_x_valid_o && !sample_x_ready_i |=> sample_x_valid_o && $stable(sample_x_o))
		else $error("sample lost");
	bound_x_a: assert property (sample_x_valid_o |-> sample_x_o <= (oversampling_ratio_i == 8'h00 ? 9'h100 : {1'b0, oversampling_ratio_i}))
		else $error("sample too big");
endmodule

// >>> verification/spdm_mic_pair.sv
// Purpose: two microphones on one data wire
// Assumes: bit clock from the device
// Notes: left may toggle for half density
`timescale 1ns/1ps
module spdm_mic_pair (
	input wire logic mic_clock_i,
	input wire logic left_i,
	input wire logic right_i,
	input wire logic toggle_i,
	output logic data_o
);
	logic phase_q;
	// left's bit must stand across the rising edge, where channel x takes it, so it is launched
	// at the falling edge; right's is launched at the rising edge and stands across the falling one
	// one process owns the shared wire, so each half period has exactly one driver
	always @(posedge mic_clock_i or negedge mic_clock_i) begin
		if (mic_clock_i) begin
			data_o <= right_i;
		end else begin
			// phase settles to zero on the first falling edge with toggle low
			phase_q <= toggle_i & ~phase_q;
			data_o <= left_i ^ (toggle_i & phase_q);
		end
	end
endmodule

// >>> verification/tb.sv
// Purpose: self-checking bench for spdm_front
// Assumes: 20 MHz clock, mic pair on pin x1
// Notes: one task per test
`timescale 1ns/1ps
`include "spdm_defines.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb;
	logic clock_i, arst_n_i, clock_enable_i, mic_clock_out_o, serial_data_in_pin_x_i, serial_data_in_pin_x1_i;
	logic redirect_x_i, start_i, sample_x_valid_o, sample_x_ready_i, sample_x1_valid_o, sample_x1_ready_i;
	logic left, right, tog;
	logic [8:0] mic_clock_divider_i;
	logic [7:0] oversampling_ratio_i, skip_count_x_i, skip_count_x1_i;
	logic [1:0] chan_enable_i, skip_load_i, skip_busy_o, overrun_o;
	logic [`SPDM_ACC_W-1:0] sample_x_o, sample_x1_o;
	int n_mismatch = 0;
	int total_checks = 0;
	int t, hi, tx, tx1, d0;
	spdm_front u_spdm_front (.*);
	spdm_mic_pair u_spdm_mic_pair (.mic_clock_i(mic_clock_out_o), .left_i(left), .right_i(right), .toggle_i(tog),
		.data_o(serial_data_in_pin_x1_i));
// ********
// tests
// ********
	// time one bit clock period; settle three periods first
	task automatic period(input logic [8:0] d, input int ep);
		@(posedge clock_i) mic_clock_divider_i <= d;
		repeat (3) @(posedge mic_clock_out_o);
		t = int'($time);
		@(negedge mic_clock_out_o);
		hi = int'($time) - t;
		@(posedge mic_clock_out_o);
		`CHK("period", ep * 50, int'($time) - t)
		`CHK("high", ep * 25, hi)
	endtask
	task automatic t_clock;
		period(9'h008, 8);
		period(9'h002, 4);
		@(negedge mic_clock_out_o);
		@(posedge clock_i) clock_enable_i <= 1'b0;
		repeat (20) @(posedge clock_i);
		#1;
		`CHK("held", 1'b0, mic_clock_out_o)
		@(posedge clock_i) clock_enable_i <= 1'b1;
		mic_clock_divider_i <= 9'h004;
		$display("clock done");
	endtask
	// pat is redirect, pin x, left, right, toggle; skip goes on x, a refused zero skip on x1
	task automatic run(input logic [7:0] ra, input logic [4:0] pat, input logic [7:0] sk, input logic [8:0] ex, ex1);
		@(posedge clock_i) oversampling_ratio_i <= ra;
		{redirect_x_i, serial_data_in_pin_x_i, left, right, tog} <= pat;
		chan_enable_i <= 2'b11;
		@(posedge mic_clock_out_o);
		@(posedge clock_i) start_i <= 1'b1;
		@(posedge clock_i) start_i <= 1'b0;
		skip_load_i <= {1'b1, sk != 8'h00};
		skip_count_x_i <= sk;
		// a second load while skipping must be ignored
		@(posedge clock_i) skip_count_x_i <= 8'h05;
		#1;
		`CHK("busy", ({1'b0, sk != 8'h00}), skip_busy_o)
		@(posedge clock_i) skip_load_i <= 2'b00;
		tx = -1;
		tx1 = -1;
		for (t = 0; t < 1200 && (tx < 0 || tx1 < 0); t++) begin
			@(posedge clock_i);
			#1;
			if (sample_x_valid_o && tx < 0) begin
				tx = t;
				`CHK("x", ex, sample_x_o)
			end
			if (sample_x1_valid_o && tx1 < 0) begin
				tx1 = t;
				`CHK("x1", ex1, sample_x1_o)
			end
		end
		`CHK("outputs", 1'b1, (tx >= 0 && tx1 >= 0))
		@(posedge clock_i) chan_enable_i <= 2'b00;
		repeat (40) @(posedge clock_i);
	endtask
	task automatic t_stereo;
		run(8'h08, 5'b10100, 8'h00, 9'h008, 9'h000);
		run(8'h08, 5'b10010, 8'h00, 9'h000, 9'h008);
		run(8'h08, 5'b01010, 8'h00, 9'h008, 9'h008);
		run(8'h08, 5'b10011, 8'h00, 9'h004, 9'h008);
		run(8'h00, 5'b10100, 8'h00, 9'h100, 9'h000);
		$display("stereo done");
	endtask
	task automatic t_skip;
		run(8'h08, 5'b10110, 8'h00, 9'h008, 9'h008);
		d0 = tx - tx1;
		run(8'h08, 5'b10110, 8'h03, 9'h008, 9'h008);
		`CHK("skip delay", 12, tx - tx1 - d0)
		$display("skip done");
	endtask
	// stall x until its fifo refuses, then drain it empty
	task automatic t_fifo;
		@(posedge clock_i) oversampling_ratio_i <= 8'h01;
		{redirect_x_i, serial_data_in_pin_x_i, left, right, tog} <= 5'b10100;
		sample_x_ready_i <= 1'b0;
		chan_enable_i <= 2'b11;
		@(posedge clock_i) start_i <= 1'b1;
		@(posedge clock_i) start_i <= 1'b0;
		repeat (100) @(posedge clock_i);
		#1;
		`CHK("overrun", 2'b01, overrun_o)
		`CHK("head", 9'h001, sample_x_o)
		@(posedge clock_i) chan_enable_i <= 2'b00;
		sample_x_ready_i <= 1'b1;
		hi = 0;
		repeat (20) begin
			#1;
			hi += sample_x_valid_o;
			@(posedge clock_i);
		end
		`CHK("drained", 16, hi)
		`CHK("overrun off", 2'b00, overrun_o)
		$display("fifo done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// clock
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	// reset ten cycles, then the tests
	initial begin
		{arst_n_i, serial_data_in_pin_x_i, redirect_x_i, start_i, left, right, tog} = '0;
		{chan_enable_i, skip_load_i, skip_count_x_i, skip_count_x1_i} = '0;
		{clock_enable_i, sample_x_ready_i, sample_x1_ready_i} = 3'h7;
		mic_clock_divider_i = 9'h004;
		oversampling_ratio_i = 8'h08;
		repeat (10) @(posedge clock_i);
		arst_n_i <= 1'b1;
		t_clock;
		t_stereo;
		t_skip;
		t_fifo;
		wrap_up;
	end
	// tests need about 2000 cycles; give up after 20000
	initial begin
		#1000000;
		n_mismatch++;
		wrap_up;
	end
endmodule
bind spdm_front spdm_front_assertions u_spdm_front_assertions (.*);
